// file: hdl/sas_pkg.sv
// Constants, types and helper functions of the SAR converter sequencer
//============================================================================
package sas_pkg;

  //==========================================================================
  // Register map (APB byte addresses)
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  OFS_CTRL0    = 8'h00;
  localparam logic [7:0]  OFS_CTRL1    = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;
  localparam logic [7:0]  OFS_RES_BASE = 8'h10;
  localparam logic [7:0]  OFS_RES_LAST = 8'h2c;

  //==========================================================================
  // Field positions
  localparam int unsigned C0_SEL_LSB   = 0;
  localparam int unsigned C0_MODE_LSB  = 3;
  localparam int unsigned C0_TRG_BIT   = 5;
  localparam int unsigned C0_START_BIT = 6;
  localparam int unsigned C0_CKLO_BIT  = 7;
  localparam int unsigned C1_GRP_LSB   = 0;
  localparam int unsigned C1_SW1_BIT   = 2;
  localparam int unsigned C1_RES10_BIT = 3;
  localparam int unsigned C1_CKHI_BIT  = 4;
  localparam int unsigned C1_VREF_BIT  = 5;
  localparam int unsigned C1_SH_BIT    = 6;
  localparam int unsigned ST_DONE_BIT  = 0;
  localparam int unsigned ST_BUSY_BIT  = 1;
  localparam logic [7:0]  CTRL0_RST    = 8'h00;
  localparam logic [7:0]  CTRL1_RST    = 8'h00;

  //==========================================================================
  // Conversion timing in conversion-clock cycles
  localparam logic [6:0]  CYC_SH10   = 7'd33;
  localparam logic [6:0]  CYC_SH8    = 7'd28;
  localparam logic [6:0]  CYC_NS10   = 7'd59;
  localparam logic [6:0]  CYC_NS8    = 7'd49;
  localparam logic [6:0]  SAMPLE_CYC = 7'd3;
  localparam logic [6:0]  NBITS10    = 7'd10;
  localparam logic [6:0]  NBITS8     = 7'd8;
  localparam logic [9:0]  MSB_MASK   = 10'h200;

  //==========================================================================
  // Types
  typedef enum logic [1:0] {
    MODE_ONESHOT = 2'b00,
    MODE_REPEAT  = 2'b01,
    MODE_SWEEP   = 2'b10,
    MODE_RSWEEP  = 2'b11
  } sas_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } sas_state_t;

  //==========================================================================
  // Helpers
  function automatic logic [2:0] div_of(input logic hi, input logic lo);
    case ({hi, lo})
      2'b10:   div_of = 3'd3;
      2'b00:   div_of = 3'd4;
      2'b01:   div_of = 3'd2;
      default: div_of = 3'd1;
    endcase
  endfunction : div_of

  function automatic logic [6:0] conv_cycles(input logic res10,
                                             input logic sh);
    if (sh) conv_cycles = res10 ? CYC_SH10 : CYC_SH8;
    else    conv_cycles = res10 ? CYC_NS10 : CYC_NS8;
  endfunction : conv_cycles

  // Last pin of the sweep group: 1, 3, 5 or 7
  function automatic logic [2:0] group_last(input logic [1:0] grp);
    group_last = {grp, 1'b1};
  endfunction : group_last

  // Last weighted pin: 0, 1, 2 or 3
  function automatic logic [2:0] weight_last(input logic [1:0] grp);
    weight_last = {1'b0, grp};
  endfunction : weight_last

endpackage : sas_pkg

// file: hdl/sas_conv_if.sv
// Link between the sequencer and its successive-approximation core
`timescale 1ns/1ps
interface sas_conv_if;
  logic       tick;
  logic       start;
  logic       abort;
  logic       res10;
  logic       sh_en;
  logic       comp_above;
  logic       busy;
  logic       done;
  logic [9:0] result;
  logic [9:0] dac_code;
  logic       sample_en;

  modport ctrl (output tick, start, abort, res10, sh_en, comp_above,
                input  busy, done, result, dac_code, sample_en);
  modport core (input  tick, start, abort, res10, sh_en, comp_above,
                output busy, done, result, dac_code, sample_en);
endinterface : sas_conv_if

// file: hdl/sas_sar_core.sv
// Successive-approximation engine: one conversion of one input
`timescale 1ns/1ps
module sas_sar_core
  import sas_pkg::*;
(
  input  wire logic   pclk,    // Main clock
  input  wire logic   presetn, // Async reset, active low
  sas_conv_if.core    cif      // Sequencer side
);
  import sas_pkg::*;

  logic       busy_reg;
  logic       done_reg;
  logic       res10_reg;
  logic       sh_reg;
  logic [6:0] cnt_reg;
  logic [6:0] total_reg;
  logic [9:0] trial_reg;
  logic [9:0] mask_reg;
  logic [9:0] result_reg;

  wire [6:0] total_w   = conv_cycles(cif.res10, cif.sh_en);
  wire [6:0] win_w     = total_reg - (res10_reg ? NBITS10 : NBITS8);
  wire       in_win    = cnt_reg >= win_w;
  wire       last_w    = cnt_reg == total_reg - 7'd1;
  wire [9:0] decided_w = cif.comp_above ? trial_reg
                                        : (trial_reg & ~mask_reg);
  wire       samp_w    = cnt_reg < (sh_reg ? SAMPLE_CYC : win_w);

  //==========================================================================
  // Conversion sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg   <= 1'b0;
      done_reg   <= 1'b0;
      res10_reg  <= 1'b0;
      sh_reg     <= 1'b0;
      cnt_reg    <= 7'd0;
      total_reg  <= 7'd0;
      trial_reg  <= 10'h000;
      mask_reg   <= 10'h000;
      result_reg <= 10'h000;
    end else begin
      done_reg <= 1'b0;
      if (cif.start) begin
        busy_reg  <= 1'b1;
        cnt_reg   <= 7'd0;
        total_reg <= total_w;
        res10_reg <= cif.res10;
        sh_reg    <= cif.sh_en;
        trial_reg <= MSB_MASK;
        mask_reg  <= MSB_MASK;
      end else if (cif.abort) begin
        busy_reg <= 1'b0;
      end else if (busy_reg && cif.tick) begin
        cnt_reg <= cnt_reg + 7'd1;
        if (in_win) begin
          trial_reg <= decided_w | (mask_reg >> 1);
          mask_reg  <= mask_reg >> 1;
        end
        if (last_w) begin
          busy_reg   <= 1'b0;
          done_reg   <= 1'b1;
          // Short mode keeps the top eight bits only
          result_reg <= res10_reg ? decided_w
                                  : {2'b00, decided_w[9:2]};
        end
      end
    end
  end

  assign cif.busy      = busy_reg;
  assign cif.done      = done_reg;
  assign cif.result    = result_reg;
  // 8-bit trials still drive a 10-bit code, so the half-step offset holds
  assign cif.dac_code  = trial_reg;
  assign cif.sample_en = busy_reg && samp_w;

  //==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [6:0] hlp_ticks_reg;
  logic [6:0] hlp_samp_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hlp_ticks_reg <= 7'd0;
      hlp_samp_reg  <= 7'd0;
    end else if (cif.start) begin
      hlp_ticks_reg <= 7'd0;
      hlp_samp_reg  <= 7'd0;
    end else if (busy_reg && cif.tick) begin
      hlp_ticks_reg <= hlp_ticks_reg + 7'd1;
      if (cif.sample_en)
        hlp_samp_reg <= hlp_samp_reg + 7'd1;
    end
  end

  property p_conv_cycles;
    done_reg |-> hlp_ticks_reg == conv_cycles(res10_reg, sh_reg);
  endproperty
  a_conv_cycles: assert property (p_conv_cycles)
    else $error("conversion length wrong");

  property p_sample3;
    done_reg && sh_reg |-> hlp_samp_reg == 7'd3;
  endproperty
  a_sample3: assert property (p_sample3)
    else $error("sample window not three cycles");

  property p_res8;
    done_reg && !res10_reg |-> result_reg[9:8] == 2'b00;
  endproperty
  a_res8: assert property (p_res8)
    else $error("8-bit result wider than 8 bits");

endmodule : sas_sar_core

// file: hdl/sas_adc_seq.sv
// SAR converter sequencer: APB registers, clock divider, mode control
`timescale 1ns/1ps
module sas_adc_seq
  import sas_pkg::*;
(
  input  wire logic              pclk,                 // Main clock
  input  wire logic              presetn,              // Async reset
  input  wire logic              psel,                 // APB select
  input  wire logic              penable,              // APB enable
  input  wire logic              pwrite,               // APB direction
  input  wire logic [sas_pkg::ADDR_W-1:0] paddr,       // APB address
  input  wire logic [31:0]       pwdata,               // APB write data
  output logic      [31:0]       prdata,               // APB read data
  output logic                   pready,               // APB ready
  output logic                   pslverr,              // APB error
  input  wire logic              ext_conv_trigger_pin, // Trigger pin
  input  wire logic              comp_above,           // Comparator
  output logic      [2:0]        analog_input_sel,     // Input mux
  output logic      [9:0]        dac_code,             // Trial code
  output logic                   sample_en,            // Sample switch
  output logic                   vref_connect,         // Reference on
  output logic                   conv_done_req,        // Done request
  output logic                   conv_busy             // Converting
);
  import sas_pkg::*;

  sas_conv_if cif ();

  sas_sar_core u_core (
    .pclk    (pclk),
    .presetn (presetn),
    .cif     (cif.core)
  );

  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl0_next;
  logic [7:0] ctrl1_reg;
  logic       done_reg;
  logic       done_next;
  logic [9:0] result_reg [8];
  logic [2:0] ch_reg;
  logic [2:0] ch_next;
  logic       pass_reg;
  logic       pass_next;
  logic [2:0] div_cnt_reg;
  logic       trig_s1_reg;
  logic       trig_s2_reg;
  logic       trig_s3_reg;
  logic [31:0] prdata_reg;
  logic       pslverr_reg;
  sas_state_t state_reg;
  sas_state_t state_next;

  //==========================================================================
  // Field decode
  wire [2:0]  sel_w      = ctrl0_reg[C0_SEL_LSB +: 3];
  wire sas_mode_t mode_w = sas_mode_t'(ctrl0_reg[C0_MODE_LSB +: 2]);
  wire        trg_w      = ctrl0_reg[C0_TRG_BIT];
  wire        flag_w     = ctrl0_reg[C0_START_BIT];
  wire [1:0]  grp_w      = ctrl1_reg[C1_GRP_LSB +: 2];
  wire        sw1_w      = ctrl1_reg[C1_SW1_BIT];
  wire [2:0]  div_w      = div_of(ctrl1_reg[C1_CKHI_BIT],
                                  ctrl0_reg[C0_CKLO_BIT]);
  wire        sweep_w    = mode_w[1];
  wire        rep_w      = mode_w[0];
  // Weighting only applies to repeat sweep with the mode-1 bit set
  wire        weighted_w = (mode_w == MODE_RSWEEP) && sw1_w;
  wire [2:0]  last_ch_w  = (weighted_w && pass_reg) ? weight_last(grp_w)
                                                    : group_last(grp_w);
  wire [2:0]  first_ch_w = sweep_w ? 3'd0 : sel_w;

  //==========================================================================
  // Conversion clock divider
  wire tick_w = div_cnt_reg >= div_w - 3'd1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_cnt_reg <= 3'd0;
    else          div_cnt_reg <= tick_w ? 3'd0 : div_cnt_reg + 3'd1;
  end

  //==========================================================================
  // Trigger pin synchroniser and falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_s1_reg <= 1'b1;
      trig_s2_reg <= 1'b1;
      trig_s3_reg <= 1'b1;
    end else begin
      trig_s1_reg <= ext_conv_trigger_pin;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
    end
  end
  wire trig_fall_w = trig_s3_reg & ~trig_s2_reg;

  //==========================================================================
  // Sequencer
  wire core_done_w = (state_reg == ST_RUN) && cif.done;
  wire at_last_w   = !sweep_w || (ch_reg == last_ch_w);
  // Run ends after one-shot or after the last pin of a single sweep
  wire finish_w    = core_done_w && !rep_w && at_last_w;
  wire cont_w      = core_done_w && !finish_w && flag_w;
  wire ext_go_w    = trg_w && flag_w && trig_fall_w &&
                     (state_reg != ST_IDLE);
  wire sw_go_w     = (state_reg == ST_IDLE) && flag_w && !trg_w;
  wire launch_w    = sw_go_w || ext_go_w || cont_w;

  always_comb begin
    state_next = state_reg;
    ch_next    = ch_reg;
    pass_next  = pass_reg;
    if (!flag_w) begin
      state_next = ST_IDLE;
    end else if (sw_go_w || ext_go_w) begin
      // A fresh edge mid-conversion restarts from the first input
      state_next = ST_RUN;
      ch_next    = first_ch_w;
      pass_next  = 1'b0;
    end else if (state_reg == ST_IDLE) begin
      state_next = ST_WAIT;
    end else if (finish_w) begin
      state_next = trg_w ? ST_WAIT : ST_IDLE;
    end else if (cont_w) begin
      if (!sweep_w) begin
        ch_next = sel_w;
      end else if (!at_last_w) begin
        ch_next = ch_reg + 3'd1;
      end else begin
        ch_next   = 3'd0;
        pass_next = weighted_w ? ~pass_reg : 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      ch_reg    <= 3'd0;
      pass_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      ch_reg    <= ch_next;
      pass_reg  <= pass_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) result_reg[i] <= 10'h000;
    end else if (core_done_w) begin
      result_reg[ch_reg] <= cif.result;
    end
  end

  assign cif.tick       = tick_w;
  assign cif.start      = launch_w;
  assign cif.abort      = (state_reg == ST_RUN) && !flag_w;
  assign cif.res10      = ctrl1_reg[C1_RES10_BIT];
  assign cif.sh_en      = ctrl1_reg[C1_SH_BIT];
  assign cif.comp_above = comp_above;

  //==========================================================================
  // APB slave: zero wait states, read data captured in the setup cycle
  wire acc_w    = psel & penable;
  wire setup_w  = psel & ~penable;
  wire hit_c0   = paddr == OFS_CTRL0;
  wire hit_c1   = paddr == OFS_CTRL1;
  wire hit_st   = paddr == OFS_STATUS;
  wire hit_res  = (paddr >= OFS_RES_BASE) && (paddr <= OFS_RES_LAST) &&
                  (paddr[1:0] == 2'b00);
  wire [7:0] res_off = paddr - OFS_RES_BASE;
  wire [2:0] res_idx = res_off[4:2];
  wire mapped_w = hit_c0 | hit_c1 | hit_st | hit_res;
  wire wr_c0    = acc_w & pwrite & hit_c0;
  wire wr_c1    = acc_w & pwrite & hit_c1;
  wire wr_st    = acc_w & pwrite & hit_st;
  wire [31:0] rdata_w =
      hit_c0  ? {24'h000000, ctrl0_reg} :
      hit_c1  ? {24'h000000, ctrl1_reg} :
      hit_st  ? {30'h0, state_reg != ST_IDLE, done_reg} :
      hit_res ? {22'h0, result_reg[res_idx]} : 32'h00000000;

  // Completion outside trigger mode drops the start flag; a same-cycle software write wins
  always_comb begin
    ctrl0_next = ctrl0_reg;
    if (finish_w && !trg_w) ctrl0_next[C0_START_BIT] = 1'b0;
    if (wr_c0) ctrl0_next = pwdata[7:0];
  end

  // Set beats write-one-to-clear
  assign done_next = (done_reg & ~(wr_st & pwdata[ST_DONE_BIT])) |
                     finish_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg   <= CTRL0_RST;
      ctrl1_reg   <= CTRL1_RST;
      done_reg    <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl0_reg <= ctrl0_next;
      if (wr_c1) ctrl1_reg <= pwdata[7:0];
      done_reg  <= done_next;
      if (setup_w) begin
        prdata_reg  <= rdata_w;
        pslverr_reg <= ~mapped_w;
      end
    end
  end

  assign prdata           = prdata_reg;
  assign pready           = 1'b1;
  assign pslverr          = pslverr_reg;
  assign analog_input_sel = ch_reg;
  assign dac_code         = cif.dac_code;
  assign sample_en        = cif.sample_en;
  assign vref_connect     = ctrl1_reg[C1_VREF_BIT];
  assign conv_done_req    = done_reg;
  assign conv_busy        = cif.busy;

  //==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [2:0] hlp_gap_reg;
  logic       hlp_seen_reg;
  logic       hlp_chg_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hlp_gap_reg  <= 3'd0;
      hlp_seen_reg <= 1'b0;
      hlp_chg_reg  <= 1'b0;
    end else begin
      hlp_gap_reg  <= tick_w ? 3'd0 : hlp_gap_reg + 3'd1;
      hlp_seen_reg <= hlp_seen_reg | tick_w;
      hlp_chg_reg  <= tick_w ? 1'b0 : (hlp_chg_reg | (div_w != $past(div_w)));
    end
  end

  property p_div;
    tick_w && hlp_seen_reg && !hlp_chg_reg && $stable(div_w)
      |-> hlp_gap_reg == div_w - 3'd1;
  endproperty
  a_div: assert property (p_div)
    else $error("conversion clock period wrong");

  property p_oneshot_end;
    core_done_w && mode_w == MODE_ONESHOT && !trg_w && !wr_c0
      |=> !flag_w && done_reg && state_reg == ST_IDLE;
  endproperty
  a_oneshot_end: assert property (p_oneshot_end)
    else $error("one-shot completion not handled");

  property p_ext_start;
    state_reg == ST_WAIT && flag_w && trg_w && trig_fall_w && !wr_c0
      |-> cif.start ##1 state_reg == ST_RUN;
  endproperty
  a_ext_start: assert property (p_ext_start)
    else $error("trigger edge did not start conversion");

  property p_repeat;
    core_done_w && mode_w == MODE_REPEAT && flag_w
      |-> cif.start ##1 (state_reg == ST_RUN && ch_reg == $past(sel_w));
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("repeat mode did not continue");

  property p_sweep_order;
    core_done_w && sweep_w && flag_w && ch_reg != last_ch_w && !wr_c0
      |=> ch_reg == $past(ch_reg) + 3'd1;
  endproperty
  a_sweep_order: assert property (p_sweep_order)
    else $error("sweep order not ascending");

  property p_single_end;
    core_done_w && mode_w == MODE_SWEEP && ch_reg == last_ch_w && !trg_w
      && !wr_c0 |=> state_reg == ST_IDLE && done_reg;
  endproperty
  a_single_end: assert property (p_single_end)
    else $error("single sweep did not stop");

  covers_oneshot: cover property (core_done_w && mode_w == MODE_ONESHOT);
  cover_ext_restart: cover property (state_reg == ST_RUN && ext_go_w);
  cover_weighted: cover property (cont_w && weighted_w && pass_reg);

endmodule : sas_adc_seq

// file: test/sas_analog_model.sv
// Analog side model: input levels, sample switch and comparator
`timescale 1ns/1ps
module sas_analog_model (
  input  wire logic       pclk,       // Main clock
  input  wire logic [2:0] sel,        // Selected input
  input  wire logic [9:0] dac_code,   // Trial code
  input  wire logic       sample_en,  // Sample switch
  input  wire logic [9:0] lvl [8],    // Input levels as codes
  output logic            comp_above  // Comparator
);
  // Pins are only ever read here, as inputs set by software
  logic [9:0] held;
  // Tracks the chosen input only while sampling
  always_ff @(posedge pclk) if (sample_en) held <= lvl[sel];
  // Threshold of code n sits half a step below n
  assign comp_above = held >= dac_code;
endmodule : sas_analog_model

// file: test/test_sas_adc_seq.sv
// Self-checking bench of the SAR converter sequencer
`timescale 1ns/1ps
module test_sas_adc_seq;
  import sas_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, trigger_source_select = 1, comp, vref, done, busy, smp;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rnd = 32'h8693;
  logic [2:0]  sel;
  logic [9:0]  dac, lvl [8];
  logic [32:0] expq [$];
  logic [2:0]  seen [$];
  logic        bz = 0;
  int          fails = 0, checks = 0, cyc = 0, t0;
  int          dv [4] = '{4, 2, 3, 1};

  sas_adc_seq u_sas_adc_seq (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_conv_trigger_pin(trigger_source_select), .comp_above(comp),
    .analog_input_sel(sel), .dac_code(dac), .sample_en(smp),
    .vref_connect(vref), .conv_done_req(done), .conv_busy(busy));
  sas_analog_model u_sas_analog_model (.pclk(pclk), .sel(sel),
    .dac_code(dac), .sample_en(smp), .lvl(lvl), .comp_above(comp));

  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  // Order of inputs visited, noted as each conversion begins; keying on
  // the mux alone misses a repeated pin and races the queue reset
  always @(posedge pclk) begin
    if (busy && !bz) seen.push_back(sel);
    bz = busy;
  end
  always @(posedge pclk) if (psel && penable && pready && !pwrite)
    check({pslverr, prdata}, expq.pop_front());

  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction : xs
  task automatic check(logic [32:0] got, logic [32:0] want);
    checks++;
    if (got !== want) begin
      fails++;
      $display("Error %0t: got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(logic [7:0] a, logic [32:0] e);
    expq.push_back(e);
    apb(0, a, 0);
  endtask : rd
  // Waits until busy (b = 1) or the done request (b = 0) equals v
  task automatic wt(logic b, logic v);
    repeat (5000) if ((b ? busy : done) !== v) @(posedge pclk);
  endtask : wt
  task automatic results();
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    results();
  end

  initial begin
    foreach (lvl[i]) lvl[i] = 10'(xs());
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(OFS_CTRL1, 0);
    rd(8'h40, {1'b1, 32'h0});
    for (int i = 0; i < 8; i++) begin
      automatic logic r10 = i[2];
      automatic logic sh = i[0] ^ i[2];
      automatic int cy = sh ? (r10 ? 33 : 28) : (r10 ? 59 : 49);
      automatic int n = dv[{i[0], i[1]}];
      // Sample-and-hold needs at least 1 MHz; all ratios here keep it
      apb(1, OFS_CTRL1, {25'h0, sh, 1'b1, i[0], r10, 3'h0});
      repeat (100) @(posedge pclk);
      apb(1, OFS_CTRL0, {24'h0, i[1], 2'b10, 2'b00, 3'(i)});
      t0 = cyc;
      wt(0, 1);
      check(cyc - t0 >= (cy - 1) * n + 1, 1);
      check(cyc - t0 <= (cy + 1) * n + 3, 1);
      rd(OFS_RES_BASE + 8'(4 * i),
         r10 ? 33'(lvl[i]) : 33'(lvl[i][9:2]));
      rd(OFS_CTRL0, {25'h0, i[1], 4'h0, 3'(i)});
      rd(OFS_STATUS, 1);
      apb(1, OFS_STATUS, 1);
    end
    apb(1, OFS_CTRL1, 32'h71);
    apb(1, OFS_CTRL0, 32'hd0);
    seen.delete();
    t0 = cyc;
    wt(0, 1);
    check(cyc - t0 >= 4 * 28, 1);
    for (int k = 0; k < 4; k++) begin
      check(seen[k], k);
      rd(OFS_RES_BASE + 8'(4 * k), 33'(lvl[k][9:2]));
    end
    rd(OFS_CTRL0, 32'h90);
    apb(1, OFS_STATUS, 1);
    for (int m = 0; m < 2; m++) begin
      apb(1, OFS_CTRL1, 32'h71 | (m << 2));
      apb(1, OFS_CTRL0, 32'hd8);
      seen.delete();
      repeat (3000) if (seen.size() < 7) @(posedge pclk);
      for (int k = 0; k < 7; k++)
        check(seen[k], m ? (k % 6 < 4 ? k % 6 : k % 6 - 4) : k % 4);
      check(done, 0);
      apb(1, OFS_CTRL0, 32'h98);
      // Abort drops busy at the edge after the write lands
      @(posedge pclk);
      check(busy, 0);
    end
    apb(1, OFS_CTRL0, 32'hcd);
    repeat (40) @(posedge pclk);
    lvl[5] <= 10'(xs());
    // Three conversions of 28 ticks so a fresh one has finished
    repeat (3 * 28 + 8) @(posedge pclk);
    rd(OFS_RES_BASE + 8'h14, 33'(lvl[5][9:2]));
    check(done, 0);
    apb(1, OFS_CTRL0, 32'h8d);
    @(posedge pclk);
    check(busy, 0);
    apb(1, OFS_CTRL0, 32'he2);
    repeat (20) @(posedge pclk);
    check(busy, 0);
    trigger_source_select <= 0;
    wt(1, 1);
    check(busy, 1);
    repeat (10) @(posedge pclk);
    trigger_source_select <= 1;
    repeat (2) @(posedge pclk);
    trigger_source_select <= 0;
    t0 = cyc;
    wt(0, 1);
    check(cyc - t0 >= 28, 1);
    rd(OFS_RES_BASE + 8'h08, 33'(lvl[2][9:2]));
    rd(OFS_CTRL0, 32'he2);
    results();
  end
endmodule : test_sas_adc_seq
